// >>> verilog/adc_seq_map.svh
// Register map, field positions and timing constants of the converter sequencer.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODE0     8'h00
`define OFS_MODE1     8'h04
`define OFS_INSEL     8'h08
`define OFS_TRGSEL    8'h0C
`define OFS_DMA       8'h10
`define OFS_RES_BASE  8'h20
// ****************************************
// Field positions
// ****************************************
`define M0_ENABLE     7
`define M0_ACTIVE     6
`define M0_BUF        5
`define M0_SCAN       4
`define M1_EDGE_HI    7
`define M1_EDGE_LO    6
`define M1_TRG_HI     5
`define M1_TRG_LO     4
`define RES_LSB       6
// ****************************************
// Counts and encodings
// ****************************************
`define CMP_STEPS     4'd10
`define LAST_CHAN     4'd9
`define GROUP_LAST    2'd3
`define PAIR_LAST     2'd1
`define PAIR_BASE     4'd8
`define TSEL_MAX      4'd8
`define ZERO_WORD     32'h0000_0000
`endif

// >>> verilog/adc_seq_pkg.sv
// Types shared by the converter sequencer.
// Assumes the map header supplies the register offsets, field positions and counts.
package adc_seq_pkg;
  typedef enum logic [1:0] {TRG_SELF, TRG_TIMER, TRG_EXT, TRG_BAD} trig_mode_t;
  typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_CONVERT} seq_state_t;
endpackage

// >>> verilog/adc_trigger_sequencer.sv
// Trigger, sequencing and result storage of one 10-bit SAR converter.
// Assumes an AHB-Lite master, a comparator answering one bit per clock,
// and timer events that are one-cycle pulses on hclk.
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module adc_trigger_sequencer #(
  parameter int NCH = 10
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [7:0]              haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic [7:0]              timer_events,
  input  wire logic                    ext_trigger_pin,
  input  wire logic                    cmp_bit,
  output logic [3:0]                   analog_input,
  output logic                         sample_start,
  output logic                         conversion_end_irq,
  output adc_seq_pkg::trig_mode_t      trig_mode
);
  import adc_seq_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  // Register file and bus pipeline state
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic [7:0] mode0_q, mode1_q;
  logic [3:0] insel_q, trgsel_q;
  logic [9:0] dma_val_q;
  logic       ovr_q, dma_fresh_q;
  logic [9:0] res_q [NCH];
  logic       rd_pend_q;
  // Address phase taken only while the bus is ready; strobes act in the data phase
  wire        addr_ph = hsel & hready & htrans[1];
  wire        wr_mode0 = wr_pend_q & (wr_addr_q == `OFS_MODE0);
  wire        wr_mode1 = wr_pend_q & (wr_addr_q == `OFS_MODE1);
  wire        wr_insel = wr_pend_q & (wr_addr_q == `OFS_INSEL);
  wire        wr_trgsel = wr_pend_q & (wr_addr_q == `OFS_TRGSEL);
  wire        mode_wr = wr_mode0 | wr_mode1 | wr_insel;
  // Read side effects wait for the data phase, or the flag would clear before it is seen
  wire        rd_dma = rd_pend_q & (rd_addr_q == `OFS_DMA);
  wire [7:0]  res_off = rd_addr_q - `OFS_RES_BASE;
  wire [3:0]  res_idx = res_off[5:2];
  wire        res_hit = (rd_addr_q >= `OFS_RES_BASE) && (res_off[7:6] == 2'b00) &&
                        (res_idx <= `LAST_CHAN) && (res_off[1:0] == 2'b00);

  // Zero wait states; a write lands at the edge that ends its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      rd_pend_q <= addr_ph & ~hwrite;
      wr_addr_q <= haddr;
      rd_addr_q <= haddr;
    end
  end

  // Never stalls and never errors, so the master needs no retry path
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************
  // Trigger decode and pin synchroniser
  // ****************************************
  // Two synchroniser flops plus one history flop for edge detection
  logic [2:0] pin_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pin_q <= 3'b000;
    else pin_q <= {pin_q[1:0], ext_trigger_pin};
  end
  // Edges use only settled flops; the first may still be metastable
  wire rise = pin_q[1] & ~pin_q[2];
  wire fall = ~pin_q[1] & pin_q[2];
  wire enable = mode0_q[`M0_ENABLE];
  wire edge_hit = (mode1_q[`M1_EDGE_HI] & rise) | (mode1_q[`M1_EDGE_LO] & fall);
  wire [1:0] trg_field = {mode1_q[`M1_TRG_HI], mode1_q[`M1_TRG_LO]};
  assign trig_mode = trig_mode_t'(trg_field);
  // Prohibited source codes select nothing rather than an arbitrary event
  wire tsel_ok = (trgsel_q != 4'd0) && (trgsel_q <= `TSEL_MAX);
  wire [2:0] tsel_idx = 3'(trgsel_q - 4'd1);
  wire timer_hit = tsel_ok & timer_events[tsel_idx];
  wire trig = (trig_mode == TRG_TIMER) ? timer_hit : (trig_mode == TRG_EXT) ? edge_hit : 1'b0;
  wire ext_restart = (trig_mode == TRG_EXT) & edge_hit;

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t st_q;
  logic [3:0] step_q, chan_q;
  logic [1:0] grp_q;
  logic [9:0] sar_q;
  // Channel and buffer selection for the conversion in progress
  wire buf4 = mode0_q[`M0_BUF];
  wire scan = mode0_q[`M0_SCAN];
  wire [3:0] top = (insel_q > `LAST_CHAN) ? `LAST_CHAN : insel_q;
  wire [1:0] grp_last = (top >= `PAIR_BASE) ? `PAIR_LAST : `GROUP_LAST;
  wire [3:0] grp_base = (top >= `PAIR_BASE) ? `PAIR_BASE : {top[3:2], 2'b00};
  wire [3:0] conv_ch = scan ? chan_q : top;
  wire [3:0] store_ch = (buf4 & ~scan) ? 4'(grp_base + 4'(grp_q)) : conv_ch;
  // Last decision joins directly, so the result is whole at the final step
  wire [9:0] result = {sar_q[9:1], cmp_bit};
  wire done = (st_q == ST_CONVERT) & (step_q == `CMP_STEPS - 4'd1) & ~mode_wr & ~ext_restart;
  wire seq_end = scan ? (chan_q == top) : buf4 ? (grp_q == grp_last) : 1'b1;
  wire self_mode = (trig_mode == TRG_SELF);

  // Converter-side outputs follow the sequencer state directly
  assign analog_input = conv_ch;
  assign sample_start = (st_q == ST_CONVERT) & (step_q == 4'd0);

  // Abort on mode writes wins over completion, so a stale result is never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_OFF;
      step_q <= 4'd0;
      chan_q <= 4'd0;
      grp_q <= 2'd0;
      sar_q <= 10'd0;
      conversion_end_irq <= 1'b0;
    end else begin
      conversion_end_irq <= done & seq_end;
      if (!enable) begin
        st_q <= ST_OFF;
        step_q <= 4'd0;
        chan_q <= 4'd0;
        grp_q <= 2'd0;
      end else if (mode_wr && st_q == ST_CONVERT) begin
        step_q <= 4'd0;
      end else begin
        case (st_q)
          ST_OFF: begin
            st_q <= self_mode ? ST_CONVERT : ST_STANDBY;
            step_q <= 4'd0;
          end
          ST_STANDBY: begin
            if (trig) begin
              st_q <= ST_CONVERT;
              step_q <= 4'd0;
            end
          end
          ST_CONVERT: begin
            if (ext_restart) step_q <= 4'd0;
            else if (done) begin
              step_q <= 4'd0;
              st_q <= self_mode ? ST_CONVERT : ST_STANDBY;
              chan_q <= (scan && !seq_end) ? 4'(chan_q + 4'd1) : 4'd0;
              grp_q <= (buf4 && !seq_end) ? 2'(grp_q + 2'd1) : 2'd0;
            end else begin
              step_q <= 4'(step_q + 4'd1);
              sar_q[4'd9 - step_q] <= cmp_bit;
            end
          end
          default: st_q <= ST_OFF;
        endcase
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Active bit is live status; writes to it are dropped
  wire [7:0] mode0_rd = {mode0_q[7], st_q == ST_CONVERT, mode0_q[5:0]};
  // Mode registers take the data-phase write data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode0_q <= 8'h00;
      mode1_q <= 8'h00;
      insel_q <= 4'h0;
      trgsel_q <= 4'h0;
    end else begin
      if (wr_mode0) mode0_q <= {hwdata[7], 1'b0, hwdata[5:0]};
      if (wr_mode1) mode1_q <= hwdata[7:0];
      if (wr_insel) insel_q <= hwdata[3:0];
      if (wr_trgsel) trgsel_q <= hwdata[3:0];
    end
  end

  // Result store per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_res
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) res_q[g] <= 10'd0;
        else if (done && store_ch == 4'(g)) res_q[g] <= result;
      end
    end
  endgenerate

  // DMA word: new result beats the read clear of freshness
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_val_q <= 10'd0;
      ovr_q <= 1'b0;
      dma_fresh_q <= 1'b0;
    end else if (!enable) begin
      ovr_q <= 1'b0;
      dma_fresh_q <= rd_dma ? 1'b0 : dma_fresh_q;
    end else if (done) begin
      dma_val_q <= result;
      dma_fresh_q <= 1'b1;
      if (dma_fresh_q && !rd_dma) ovr_q <= 1'b1;
      else if (rd_dma) ovr_q <= 1'b0;
    end else if (rd_dma) begin
      dma_fresh_q <= 1'b0;
      ovr_q <= 1'b0;
    end
  end

  // Read mux
  wire [31:0] rd_word =
      (rd_addr_q == `OFS_MODE0)  ? {24'h00_0000, mode0_rd} :
      (rd_addr_q == `OFS_MODE1)  ? {24'h00_0000, mode1_q} :
      (rd_addr_q == `OFS_INSEL)  ? {28'h000_0000, insel_q} :
      (rd_addr_q == `OFS_TRGSEL) ? {28'h000_0000, trgsel_q} :
      (rd_addr_q == `OFS_DMA)    ? {16'h0000, dma_val_q, 5'b00000, ovr_q} :
      res_hit                    ? {16'h0000, res_q[res_idx], 6'b000000} : `ZERO_WORD;
  assign hrdata = rd_pend_q ? rd_word : `ZERO_WORD;

  // ****************************************
  // Checks
  // ****************************************
  irq_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    conversion_end_irq |=> !conversion_end_irq)
    else $error("irq wider than one cycle");
  ovr_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> !ovr_q)
    else $error("overrun kept while disabled");
  abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode_wr && st_q == ST_CONVERT && enable) |=> step_q == 4'd0)
    else $error("no restart");
  self_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_OFF && enable && self_mode) |=> st_q == ST_CONVERT)
    else $error("no self start");
  standby_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && !self_mode && enable) |=> st_q == ST_STANDBY)
    else $error("no standby");
  dma_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && enable) |=> dma_val_q == $past(result))
    else $error("dma not updated");
  ovr_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && enable && dma_fresh_q && !rd_dma) |=> ovr_q)
    else $error("overrun missed");
  ten_steps_a: assert property (@(posedge hclk) disable iff (!hresetn)
    done |-> $past(sample_start, 9))
    else $error("conversion not ten steps long");
  ext_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_CONVERT && enable && ext_restart && !mode_wr) |=> step_q == 4'd0)
    else $error("edge did not restart");
  self_repeat_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && self_mode && enable) |=> (st_q == ST_CONVERT && step_q == 4'd0))
    else $error("self mode did not repeat");
  edge_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_STANDBY && enable && trig_mode == TRG_EXT && edge_hit) |=> st_q == ST_CONVERT)
    else $error("edge did not start");
  no_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == ST_STANDBY && enable && trig_mode == TRG_TIMER && !tsel_ok) |=> st_q == ST_STANDBY)
    else $error("start without a source");
  group_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && buf4 && !scan && grp_q != grp_last) |=> !conversion_end_irq)
    else $error("irq before group end");
  scan_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && scan && chan_q != top) |=> !conversion_end_irq)
    else $error("irq before last input");
  dma_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_dma && !done && enable) |=> (!ovr_q && !dma_fresh_q))
    else $error("read did not clear flags");
endmodule

// >>> verif/adc_far_side.sv
// Far-side model: comparator decisions, timer event pulses, trigger pin.
// Assumes sample_start marks conversion step 0 and one decision per clock.
`timescale 1ns/1ps
module adc_far_side (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       sample_start,
  input  wire logic [9:0] cmp_val,
  input  wire logic [7:0] ev_cmd,
  input  wire logic       pin_cmd,
  output logic            cmp_bit,
  output logic [7:0]      timer_events,
  output logic            ext_trigger_pin
);
  logic [3:0] step_q;
  logic [3:0] idx;
  // Step count restarts on every sample pulse, saturates when idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) step_q <= 4'h0;
    else step_q <= sample_start ? 4'h1 : ((step_q == 4'hF) ? step_q : step_q + 4'h1);
  end
  assign idx = sample_start ? 4'h0 : step_q;
  // MSB first; outside a conversion the line shows the inverse of the last bit
  assign cmp_bit = (idx < 4'hA) ? cmp_val[4'd9 - idx] : ~cmp_val[0];
  // Events and the pin copy their commands, launched one edge after the command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_events    <= 8'h00;
      ext_trigger_pin <= 1'b0;
    end else begin
      timer_events    <= ev_cmd;
      ext_trigger_pin <= pin_cmd;
    end
  end
endmodule

// >>> verif/tb_adc_trigger_sequencer.sv
// Self-checking bench for the converter sequencer over AHB-Lite.
// Assumes the far-side model supplies comparator bits and trigger events.
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module tb_adc_trigger_sequencer;
  import adc_seq_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pin_cmd = 0;
  logic        hreadyout, hresp, cmp_bit, sample_start, conversion_end_irq, ext_trigger_pin;
  logic [7:0]  haddr = 8'h00, ev_cmd = 8'h00, timer_events;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic [9:0]  cmp_val = 10'h000;
  logic [3:0]  analog_input;
  trig_mode_t  trig_mode;
  int          bad_count = 0, checked = 0, st;
  logic [3:0]  row_ch [4] = '{4'h0, 4'h3, 4'h7, 4'h9};
  logic [9:0]  row_val [4] = '{10'h3FF, 10'h000, 10'h2A5, 10'h155};
  // ****
  // Clock, design and far side
  // ****
  always #50 hclk = ~hclk;
  adc_trigger_sequencer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_events(timer_events), .ext_trigger_pin(ext_trigger_pin),
    .cmp_bit(cmp_bit), .analog_input(analog_input), .sample_start(sample_start),
    .conversion_end_irq(conversion_end_irq), .trig_mode(trig_mode));
  adc_far_side far (.hclk(hclk), .hresetn(hresetn), .sample_start(sample_start), .cmp_val(cmp_val),
    .ev_cmd(ev_cmd), .pin_cmd(pin_cmd), .cmp_bit(cmp_bit), .timer_events(timer_events),
    .ext_trigger_pin(ext_trigger_pin));
  // ****
  // Tasks
  // ****
  task automatic wrap_up;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin bad_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin bad_count++; $display("ERROR %s expected %0d seen %0d", nm, e, g); end
  endtask
  // Single word transfer; the slave's ready decides, a bound stops a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1; hwrite <= w; haddr <= a; htrans <= 2'b10;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin bad_count++; wrap_up(); end
  endtask
  // Counts conversion starts until the end pulse; a start in the pulse cycle belongs to the next run
  task automatic wait_irq;
    int n;
    n = 0;
    st = 0;
    do begin
      @(posedge hclk);
      n++;
      if (sample_start === 1'b1 && conversion_end_irq !== 1'b1) st++;
    end while (conversion_end_irq !== 1'b1 && n < 2000);
    if (n >= 2000) begin bad_count++; wrap_up(); end
    @(posedge hclk);
    chk_word("irq width", 32'h0000_0000, {31'h0, conversion_end_irq});
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, `OFS_MODE0, 32'h0000_0000); chk_word("mode0 reset", 32'h0000_0000, rd);
    xfer(0, 8'h80, 32'h0000_0000); chk_word("unmapped", 32'h0000_0000, rd);
    // Self-started one-buffer rows: channel and comparator value
    for (int i = 0; i < 4; i++) begin
      cmp_val <= row_val[i];
      xfer(1, `OFS_INSEL, {28'h0, row_ch[i]});
      xfer(1, `OFS_MODE0, 32'h0000_0080);
      wait_irq(); chk_cnt("one-buffer starts", 1, st);
      chk_word("analog input", {28'h0, row_ch[i]}, {28'h0, analog_input});
      wait_irq();
      xfer(0, `OFS_DMA, 32'h0000_0000); chk_word("dma overrun", {16'h0, row_val[i], 6'h01}, rd);
      // Two more unread results raise the flag again, so only disabling can clear it below
      wait_irq();
      wait_irq();
      xfer(1, `OFS_MODE0, 32'h0000_0000);
      xfer(0, `OFS_DMA, 32'h0000_0000); chk_word("dma stopped", {16'h0, row_val[i], 6'h00}, rd);
      xfer(0, `OFS_RES_BASE + {2'b00, row_ch[i], 2'b00}, 32'h0000_0000);
      chk_word("result", {16'h0, row_val[i], 6'h00}, rd);
    end
    // Four-buffer on input 8 needs only two conversions
    cmp_val <= 10'h0C3;
    xfer(1, `OFS_INSEL, 32'h0000_0008);
    xfer(1, `OFS_MODE0, 32'h0000_00A0);
    wait_irq(); chk_cnt("four-buffer starts", 2, st);
    xfer(1, `OFS_MODE0, 32'h0000_0000);
    xfer(0, 8'h44, 32'h0000_0000); chk_word("second buffer", {16'h0, 10'h0C3, 6'h00}, rd);
    // Scan from input 0 up to input 2
    xfer(1, `OFS_INSEL, 32'h0000_0002);
    xfer(1, `OFS_MODE0, 32'h0000_0090);
    wait_irq(); chk_cnt("scan starts", 3, st);
    xfer(1, `OFS_MODE0, 32'h0000_0000);
    xfer(0, `OFS_RES_BASE, 32'h0000_0000); chk_word("scan first", {16'h0, 10'h0C3, 6'h00}, rd);
    // Timer trigger from source code 3
    xfer(1, `OFS_MODE1, 32'h0000_0010);
    xfer(1, `OFS_TRGSEL, 32'h0000_0003);
    xfer(1, `OFS_MODE0, 32'h0000_0080);
    chk_word("timer mode", {30'h0, TRG_TIMER}, {30'h0, trig_mode});
    ev_cmd <= 8'h04;
    @(posedge hclk);
    ev_cmd <= 8'h00;
    xfer(0, `OFS_MODE0, 32'h0000_0000); chk_word("active set", 32'h0000_00C0, rd);
    wait_irq();
    xfer(0, `OFS_MODE0, 32'h0000_0000); chk_word("back to standby", 32'h0000_0080, rd);
    xfer(1, `OFS_MODE0, 32'h0000_0000);
    // Source code zero: every event is ignored and the block stays in standby
    xfer(1, `OFS_TRGSEL, 32'h0000_0000);
    xfer(1, `OFS_MODE0, 32'h0000_0080);
    ev_cmd <= 8'hFF;
    @(posedge hclk);
    ev_cmd <= 8'h00;
    repeat (3) @(posedge hclk);
    xfer(0, `OFS_MODE0, 32'h0000_0000); chk_word("source none", 32'h0000_0080, rd);
    xfer(1, `OFS_MODE0, 32'h0000_0000);
    // External trigger on both edges; the second edge restarts the conversion
    xfer(1, `OFS_MODE1, 32'h0000_00E0);
    xfer(1, `OFS_MODE0, 32'h0000_0080);
    chk_word("ext mode", {30'h0, TRG_EXT}, {30'h0, trig_mode});
    pin_cmd <= 1'b1;
    fork
      begin repeat (6) @(posedge hclk); pin_cmd <= 1'b0; end
    join_none
    wait_irq(); chk_cnt("edge restarts", 2, st);
    xfer(1, `OFS_MODE0, 32'h0000_0000);
    // Reset in mid-conversion must clear mode0, the DMA word and the pulse
    xfer(1, `OFS_MODE1, 32'h0000_0000);
    xfer(1, `OFS_MODE0, 32'h0000_0080);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk_word("irq after reset", 32'h0000_0000, {31'h0, conversion_end_irq});
    xfer(0, `OFS_MODE0, 32'h0000_0000); chk_word("mode0 after reset", 32'h0000_0000, rd);
    xfer(0, `OFS_DMA, 32'h0000_0000); chk_word("dma after reset", 32'h0000_0000, rd);
    wrap_up();
  end
endmodule
